// ### logic/capture_match_counter_timer.sv
// Capture/match counter timer with APB register access.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module capture_match_counter_timer (
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ctmr_pkg::ADDR_W-1:0] paddr,
  input wire logic [ctmr_pkg::DATA_W-1:0] pwdata,
  output logic [ctmr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins.
  input wire logic [ctmr_pkg::NUM_CAP-1:0] cap_in,
  output logic [ctmr_pkg::NUM_PIN-1:0] match_out,
  // Interrupt and DMA requests.
  output logic irq,
  output logic [ctmr_pkg::NUM_DMA-1:0] dma_req
);
  import ctmr_pkg::*;

  cfg_t cfg;
  cfg_t next_cfg;
  logic [DATA_W-1:0] running_count_value;
  logic [DATA_W-1:0] next_count;
  logic [DATA_W-1:0] pre_cnt;
  logic [DATA_W-1:0] next_pre;
  logic [NUM_CAP-1:0][DATA_W-1:0] cap;
  logic [NUM_CAP-1:0][DATA_W-1:0] next_cap;
  logic [NUM_EVT-1:0] stat;
  logic [NUM_EVT-1:0] next_stat;
  logic [NUM_DMA-1:0] next_dma;
  logic [DATA_W-1:0] next_prdata;
  cap_edge_t edges;
  logic src_edge;
  logic tick;
  logic clr_ev;
  logic [NUM_MATCH-1:0] hit;
  logic [NUM_CAP-1:0] cap_ev;
  logic wr;
  logic [NUM_MATCH-1:0] wr_match;

  cap_sync #(.N(NUM_CAP)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin_in(cap_in),
    .rise(edges.rise),
    .fall(edges.fall)
  );

  // Bus handshake: no wait states while enabled, error on unmapped offsets.
  assign pready = ce;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign wr = psel && penable && pwrite && ce && addr_ok(paddr);

  always_comb
  begin
    src_edge = 1'b1;
    if (cfg.mode != CM_TIMER)
      src_edge = edge_hit(cfg.mode == CM_RISE || cfg.mode == CM_BOTH,
                          cfg.mode == CM_FALL || cfg.mode == CM_BOTH,
                          edges.rise[cfg.clk_sel], edges.fall[cfg.clk_sel]);
  end

  assign clr_ev = cfg.clr_en && edge_hit(!cfg.clr_fall, cfg.clr_fall,
                                         edges.rise[cfg.clr_ch], edges.fall[cfg.clr_ch]);

  assign tick = ce && cfg.en && !cfg.crst && src_edge && pre_cnt == cfg.pre_lim;

  always_comb
  begin
    for (int i = 0; i < NUM_MATCH; i++)
    begin
      hit[i] = tick && running_count_value == cfg.match[i];
      wr_match[i] = wr && paddr == A_MATCH0 + 8'(4 * i);
    end
  end

  always_comb
  begin
    for (int j = 0; j < NUM_CAP; j++)
      cap_ev[j] = ce && edge_hit(cfg.cctl[j].rise, cfg.cctl[j].fall,
                                 edges.rise[j], edges.fall[j]);
  end

  // Configuration registers: software writes, and stop-on-match clears enable.
  always_comb
  begin
    next_cfg = cfg;
    if (wr)
    begin
      unique case (paddr)
        A_CTRL:
        begin
          next_cfg.en = pwdata[CTRL_EN_BIT];
          next_cfg.crst = pwdata[CTRL_RST_BIT];
        end
        A_MODE:
        begin
          next_cfg.mode = count_mode_t'(pwdata[1:0]);
          next_cfg.clk_sel = pwdata[MODE_SEL_BIT];
        end
        A_PRE_LIM: next_cfg.pre_lim = pwdata;
        A_MCTL: next_cfg.mctl = pwdata[3*NUM_MATCH-1:0];
        A_CCTL:
        begin
          next_cfg.cctl = pwdata[3*NUM_CAP-1:0];
          next_cfg.clr_en = pwdata[CLR_EN_BIT];
          next_cfg.clr_ch = pwdata[CLR_CH_BIT];
          next_cfg.clr_fall = pwdata[CLR_FALL_BIT];
        end
        A_EXTM: next_cfg.act = pwdata[EXTM_ACT_LSB+2*NUM_PIN-1:EXTM_ACT_LSB];
        A_MASK: next_cfg.mask = pwdata[NUM_EVT-1:0];
        A_DMA: next_cfg.dma_en = pwdata[NUM_DMA-1:0];
        default: next_cfg = cfg;
      endcase
      for (int i = 0; i < NUM_MATCH; i++)
        if (wr_match[i])
          next_cfg.match[i] = pwdata;
    end
    for (int i = 0; i < NUM_MATCH; i++)
      if (hit[i] && cfg.mctl[i].stop)
        next_cfg.en = 1'b0;
  end

  // 32-bit count and prescaler
  // Counter and prescaler.
  always_comb
  begin
    next_count = running_count_value;
    next_pre = pre_cnt;
    if (ce)
    begin
      if (cfg.crst || clr_ev)
      begin
        next_count = COUNT_RESET;
        next_pre = COUNT_RESET;
      end
      else if (cfg.en && src_edge)
      begin
        if (pre_cnt == cfg.pre_lim)
        begin
          next_pre = COUNT_RESET;
          if (|(hit & {cfg.mctl[3].reset, cfg.mctl[2].reset,
                       cfg.mctl[1].reset, cfg.mctl[0].reset}))
            next_count = COUNT_RESET;
          else if (!(|(hit & {cfg.mctl[3].stop, cfg.mctl[2].stop,
                              cfg.mctl[1].stop, cfg.mctl[0].stop})))
            next_count = running_count_value + 32'h1;
        end
        else
          next_pre = pre_cnt + 32'h1;
      end
      if (wr && paddr == A_COUNT)
        next_count = pwdata;
      if (wr && paddr == A_PRE_CNT)
        next_pre = pwdata;
    end
  end

  always_comb
  begin
    for (int j = 0; j < NUM_CAP; j++)
      next_cap[j] = cap_ev[j] ? running_count_value : cap[j];
  end

  // Sticky status, write one to clear; a new event wins over the clear.
  always_comb
  begin
    next_stat = stat;
    if (wr && paddr == A_STAT)
      next_stat = stat & ~pwdata[NUM_EVT-1:0];
    for (int i = 0; i < NUM_MATCH; i++)
      if (hit[i] && cfg.mctl[i].irq_en)
        next_stat[i] = 1'b1;
    for (int j = 0; j < NUM_CAP; j++)
      if (cap_ev[j] && cfg.cctl[j].irq_en)
        next_stat[STAT_CAP_LSB+j] = 1'b1;
    next_dma = hit[NUM_DMA-1:0] & cfg.dma_en;
  end

  assign irq = |(stat & cfg.mask);

  // Read data is captured in the setup cycle and held through the access.
  always_comb
  begin
    next_prdata = prdata;
    if (psel && !penable && ce)
    begin
      next_prdata = '0;
      unique case (paddr)
        A_CTRL: next_prdata[CTRL_RST_BIT:CTRL_EN_BIT] = {cfg.crst, cfg.en};
        A_MODE: next_prdata[MODE_SEL_BIT:0] = {cfg.clk_sel, cfg.mode};
        A_COUNT: next_prdata = running_count_value;
        A_PRE_LIM: next_prdata = cfg.pre_lim;
        A_PRE_CNT: next_prdata = pre_cnt;
        A_MCTL: next_prdata[3*NUM_MATCH-1:0] = cfg.mctl;
        A_CCTL: next_prdata[CLR_FALL_BIT:0] = {cfg.clr_fall, cfg.clr_ch, cfg.clr_en,
                                               2'h0, cfg.cctl};
        A_CAP0: next_prdata = cap[0];
        A_CAP0 + 8'h4: next_prdata = cap[1];
        A_EXTM: next_prdata[EXTM_ACT_LSB+2*NUM_PIN-1:0] = {cfg.act, 2'h0, match_out};
        A_STAT: next_prdata[NUM_EVT-1:0] = stat;
        A_MASK: next_prdata[NUM_EVT-1:0] = cfg.mask;
        A_DMA: next_prdata[NUM_DMA-1:0] = cfg.dma_en;
        default:
        begin
          for (int i = 0; i < NUM_MATCH; i++)
            if (paddr == A_MATCH0 + 8'(4 * i))
              next_prdata = cfg.match[i];
        end
      endcase
    end
  end

  // Registers all state; the clock enable freezes it through the next values, except dma_req, which a low enable clears.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg <= CFG_RESET;
      running_count_value <= COUNT_RESET;
      pre_cnt <= COUNT_RESET;
      cap <= '0;
      stat <= '0;
      dma_req <= '0;
      prdata <= '0;
    end
    else
    begin
      cfg <= ce ? next_cfg : cfg;
      running_count_value <= next_count;
      pre_cnt <= next_pre;
      cap <= next_cap;
      stat <= next_stat;
      dma_req <= ce ? next_dma : '0;
      prdata <= next_prdata;
    end
  end

  for (genvar k = 0; k < NUM_PIN; k++)
  begin : g_pin
    match_pin u_pin (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .hit(hit[k]),
      .act(cfg.act[k]),
      .wr(wr && paddr == A_EXTM),
      .wdata(pwdata[k]),
      .pin_q(match_out[k])
    );
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic quiet;
  assign quiet = !clr_ev && !cfg.crst && !wr;

  a_count_step: assert property (tick && quiet && !(|hit) |=>
    running_count_value == $past(running_count_value) + 32'h1)
    else $error("Counter did not step at the prescaler limit.");
  a_pre_hold: assert property (ce && cfg.en && !src_edge && quiet |=>
    pre_cnt == $past(pre_cnt) && running_count_value == $past(running_count_value))
    else $error("Counter moved without a source edge.");
  a_match_reset: assert property (hit[1] && cfg.mctl[1].reset && quiet |=>
    running_count_value == 32'h0)
    else $error("Reset match did not zero the counter.");
  a_match_stop: assert property (hit[1] && cfg.mctl[1].stop && !wr |=> !cfg.en)
    else $error("Stop match did not halt the counter.");
  a_capture_load: assert property (cap_ev[0] |=> cap[0] == $past(running_count_value))
    else $error("Capture did not latch the count.");
  a_capture_clear: assert property (ce && clr_ev && !wr |=>
    running_count_value == 32'h0 && pre_cnt == 32'h0)
    else $error("Capture clear left counter or prescaler.");
  a_cap_irq: assert property (cap_ev[0] && cfg.cctl[0].irq_en |=>
    stat[STAT_CAP_LSB] && (irq || !cfg.mask[STAT_CAP_LSB]))
    else $error("Enabled capture did not raise its status.");
  a_match_irq: assert property (hit[2] && cfg.mctl[2].irq_en |=> stat[2])
    else $error("Enabled match did not raise its status.");
  a_dma_pulse: assert property (hit[0] && cfg.dma_en[0] |=> dma_req[0])
    else $error("DMA request missing after match.");
  a_dma_quiet: assert property (!(hit[0] && cfg.dma_en[0]) |=> !dma_req[0])
    else $error("DMA request without an enabled match.");

  c_match_reset: cover property (hit[1] && cfg.mctl[1].reset);
  c_capture: cover property (cap_ev[0] ##[1:50] cap_ev[0]);
  c_stop: cover property (hit[1] && cfg.mctl[1].stop);
  c_clear: cover property (clr_ev && cfg.en);

endmodule : capture_match_counter_timer
`default_nettype wire

// ### logic/ctmr_pkg.sv
// Shared constants, types and helpers of the capture/match counter timer.
`default_nettype none
package ctmr_pkg;

  // Bus and counter widths, and channel counts.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_MATCH = 4;
  localparam int NUM_CAP = 2;
  localparam int NUM_PIN = 2;
  localparam int NUM_DMA = 2;
  localparam int NUM_EVT = NUM_MATCH + NUM_CAP;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] A_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] A_PRE_LIM = 8'h0c;
  localparam logic [ADDR_W-1:0] A_PRE_CNT = 8'h10;
  localparam logic [ADDR_W-1:0] A_MCTL = 8'h14;
  localparam logic [ADDR_W-1:0] A_MATCH0 = 8'h18;
  localparam logic [ADDR_W-1:0] A_CCTL = 8'h28;
  localparam logic [ADDR_W-1:0] A_CAP0 = 8'h2c;
  localparam logic [ADDR_W-1:0] A_EXTM = 8'h34;
  localparam logic [ADDR_W-1:0] A_STAT = 8'h38;
  localparam logic [ADDR_W-1:0] A_MASK = 8'h3c;
  localparam logic [ADDR_W-1:0] A_DMA = 8'h40;

  // Field positions.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam int MODE_SEL_BIT = 2;
  localparam int CLR_EN_BIT = 8;
  localparam int CLR_CH_BIT = 9;
  localparam int CLR_FALL_BIT = 10;
  localparam int EXTM_ACT_LSB = 4;
  localparam int STAT_CAP_LSB = 4;

  // Counting source: bus clock or edges of a capture input.
  typedef enum logic [1:0] {CM_TIMER, CM_RISE, CM_FALL, CM_BOTH} count_mode_t;

  // Action of a match output pin.
  typedef enum logic [1:0] {EA_NONE, EA_LOW, EA_HIGH, EA_TOGGLE} ext_act_t;

  // Per match register control.
  typedef struct packed {
    logic stop;
    logic reset;
    logic irq_en;
  } match_ctl_t;

  // Per capture channel control.
  typedef struct packed {
    logic irq_en;
    logic fall;
    logic rise;
  } cap_ctl_t;

  // Synchronised edges of the capture inputs.
  typedef struct packed {
    logic [NUM_CAP-1:0] rise;
    logic [NUM_CAP-1:0] fall;
  } cap_edge_t;

  // Software configuration held by the block.
  typedef struct packed {
    logic en;
    logic crst;
    count_mode_t mode;
    logic clk_sel;
    logic [DATA_W-1:0] pre_lim;
    match_ctl_t [NUM_MATCH-1:0] mctl;
    logic [NUM_MATCH-1:0][DATA_W-1:0] match;
    cap_ctl_t [NUM_CAP-1:0] cctl;
    logic clr_en;
    logic clr_ch;
    logic clr_fall;
    logic [NUM_EVT-1:0] mask;
    logic [NUM_DMA-1:0] dma_en;
    ext_act_t [NUM_PIN-1:0] act;
  } cfg_t;

  // Reset values.
  localparam cfg_t CFG_RESET = '0;
  localparam logic [DATA_W-1:0] COUNT_RESET = 32'h0;
  localparam logic [NUM_PIN-1:0] PIN_RESET = 2'h0;

  // True when the selected edge kinds meet an observed edge.
  function automatic logic edge_hit(input logic on_rise, input logic on_fall,
                                    input logic rise, input logic fall);
    edge_hit = (on_rise & rise) | (on_fall & fall);
  endfunction : edge_hit

  // True for every mapped register offset.
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= A_DMA);
  endfunction : addr_ok

endpackage : ctmr_pkg
`default_nettype wire

// ### logic/cap_sync.sv
// Two-stage synchroniser and edge detector for the capture pins.
`timescale 1ns/1ps
`default_nettype none
module cap_sync #(
  parameter int N = 2
) (
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Asynchronous pins in, clean edges out.
  input wire logic [N-1:0] pin_in,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);
  logic [N-1:0] meta;
  logic [N-1:0] sync;
  logic [N-1:0] prev;
  logic [N-1:0] next_meta;
  logic [N-1:0] next_sync;
  logic [N-1:0] next_prev;

  // two flops first
  // Only the second stage reads the first; edges come from later stages.
  always_comb
  begin
    next_meta = ce ? pin_in : meta;
    next_sync = ce ? meta : sync;
    next_prev = ce ? sync : prev;
  end

  // Registers the synchroniser chain.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end
    else
    begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  // Edge pulses last one enabled cycle.
  assign rise = ce ? (sync & ~prev) : '0;
  assign fall = ce ? (~sync & prev) : '0;

  a_rise_after_sync: assert property (@(posedge pclk) disable iff (!presetn)
    rise[0] |-> $past(sync[0] == 1'b0) || $past(ce) == 1'b0)
    else $error("Rise pulse without a low synchronised level before it.");

endmodule : cap_sync
`default_nettype wire

// ### logic/match_pin.sv
// One external match output pin and its action on a match.
`timescale 1ns/1ps
`default_nettype none
module match_pin (
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Match event, chosen action and software write.
  input wire logic hit,
  input wire ctmr_pkg::ext_act_t act,
  input wire logic wr,
  input wire logic wdata,
  // Pin level, from a flop.
  output logic pin_q
);
  import ctmr_pkg::*;
  logic next_pin;

  // pin action select
  // A match wins over a software write in the same cycle.
  always_comb
  begin
    next_pin = pin_q;
    if (ce && wr)
      next_pin = wdata;
    if (ce && hit)
    begin
      unique case (act)
        EA_NONE: next_pin = pin_q;
        EA_LOW: next_pin = 1'b0;
        EA_HIGH: next_pin = 1'b1;
        EA_TOGGLE: next_pin = ~pin_q;
      endcase
    end
  end

  // Registers the pin level.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_q <= 1'b0;
    else
      pin_q <= next_pin;
  end

  a_pin_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    ce && hit && act == EA_TOGGLE |=> pin_q != $past(pin_q))
    else $error("Match pin failed to toggle.");

  a_pin_high: assert property (@(posedge pclk) disable iff (!presetn)
    ce && hit && act == EA_HIGH |=> pin_q)
    else $error("Match pin failed to go high.");

endmodule : match_pin
`default_nettype wire

// ### verif/cap_pin_model.sv
// Model of the capture input pins and match output pins around the timer.
`timescale 1ns/1ps
`default_nettype none
module cap_pin_model (
  // Clock.
  input wire logic pclk,
  // Pins seen from outside the timer.
  output logic [1:0] cap_in,
  input wire logic [1:0] match_out
);
  int pin_edges;
  logic [1:0] last_out;

  // one wire per channel.
  // Each capture pin is its own wire, so a pulse reaches one channel only.
  initial
  begin
    cap_in = 2'h0;
    pin_edges = 0;
    last_out = 2'h0;
  end

  // Drives one whole pulse on a pin, changing it only just after rising edges.
  task pulse(input int ch, input int hi, input int lo);
    @(posedge pclk);
    cap_in[ch] <= 1'b1;
    repeat (hi) @(posedge pclk);
    cap_in[ch] <= 1'b0;
    repeat (lo) @(posedge pclk);
  endtask : pulse

  // Counts every cycle in which the match pins change level.
  always @(posedge pclk)
  begin
    if (match_out !== last_out)
      pin_edges++;
    last_out <= match_out;
  end
endmodule : cap_pin_model
`default_nettype wire

// ### verif/testbench.sv
// Self-checking testbench of the capture/match counter timer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ctmr_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, r;
  logic [NUM_CAP-1:0] cap_in;
  logic [NUM_PIN-1:0] match_out;
  logic [NUM_DMA-1:0] dma_req;
  logic [DATA_W:0] exp_q[$];
  logic [1:0] lvl, nl, cur;
  int error_cnt, cmp_count, dma0_cnt, dma1_cnt, exp_edges, n;
  integer seed;

  capture_match_counter_timer i_capture_match_counter_timer (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_in(cap_in),
    .match_out(match_out), .irq(irq), .dma_req(dma_req));
  cap_pin_model i_cap_pin_model (.pclk(pclk), .cap_in(cap_in), .match_out(match_out));

  // Free running bus clock of 10 ns.
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Compares one result and counts it.
  task chk(input logic [DATA_W:0] got, input logic [DATA_W:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Samples the interrupt line away from the clock edge.
  task chk_irq(input logic e);
    @(negedge pclk);
    chk({32'h0, irq}, {32'h0, e});
  endtask : chk_irq

  // One APB transfer: setup, then access held until pready is seen.
  task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for pready; only the watchdog ends a hang here.
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // Notes the expected answer, then reads.
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic err = 1'b0);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Watches completed reads and both DMA request lines.
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite)
      chk({pslverr, prdata}, exp_q.pop_front());
    if (dma_req[0] === 1'b1)
      dma0_cnt++;
    if (dma_req[1] === 1'b1)
      dma1_cnt++;
  end

  task report_and_stop;
    $display("mismatches %0d, comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // Cuts a hang short well beyond the expected run time.
  initial
  begin
    #500000;
    error_cnt++;
    report_and_stop;
  end

  // Main sequence.
  initial
  begin
    seed = 32'h00eb0590;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    {error_cnt, cmp_count, dma0_cnt, dma1_cnt, exp_edges} = '0;
    cur = 2'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 'h40; a += 4)
      rd(ADDR_W'(a), 32'h0);
    chk({30'h0, irq, match_out}, 33'h0);
    rd(8'h44, 32'h0, 1'b1);
    rd(8'h06, 32'h0, 1'b1);
    wr(A_PRE_LIM, 32'h2);
    wr(A_MATCH0, 32'h4);
    wr(A_MCTL, 32'h5);
    wr(A_MASK, 32'h1);
    wr(A_DMA, 32'h1);
    wr(A_CTRL, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    chk(33'(n > 10), 33'h1);
    rd(A_COUNT, 32'h4);
    rd(A_CTRL, 32'h0);
    rd(A_STAT, 32'h1);
    chk(33'(dma0_cnt), 33'h1);
    wr(A_STAT, 32'h1);
    chk_irq(1'b0);
    // reset match bounds the count; continuous match keeps it running.
    wr(A_MASK, 32'h0);
    wr(A_PRE_LIM, 32'h0);
    wr(A_MATCH0 + 8'h4, 32'h2);
    wr(A_MATCH0 + 8'h8, 32'h1);
    wr(A_MATCH0 + 8'hc, 32'h5);
    wr(A_MCTL, 32'h258);
    wr(A_COUNT, 32'h0);
    wr(A_CTRL, 32'h1);
    repeat (40) @(posedge pclk);
    wr(A_CTRL, 32'h0);
    rd(A_STAT, 32'h6);
    chk_irq(1'b0);
    wr(A_STAT, 32'h3f);
    // counting edges of the second capture input in every edge mode.
    wr(A_MCTL, 32'h0);
    for (int m = 1; m < 4; m++)
    begin
      wr(A_COUNT, 32'h0);
      wr(A_MODE, 32'(4 + m));
      wr(A_CTRL, 32'h1);
      repeat (3) i_cap_pin_model.pulse(1, 5, 5);
      repeat (4) @(posedge pclk);
      wr(A_CTRL, 32'h0);
      rd(A_COUNT, (m == 3) ? 32'h6 : 32'h3);
    end
    wr(A_MODE, 32'h0);
    // a low clock enable freezes the running count for 20 cycles.
    wr(A_COUNT, 32'h100);
    wr(A_CTRL, 32'h1);
    @(posedge pclk);
    ce <= 1'b0;
    repeat (20) @(posedge pclk);
    ce <= 1'b1;
    wr(A_CTRL, 32'h0);
    rd(A_COUNT, 32'h104);
    // capture of a held count, with its interrupt.
    r = $random(seed);
    wr(A_COUNT, r);
    wr(A_STAT, 32'h3f);
    wr(A_CCTL, 32'h5);
    wr(A_MASK, 32'h10);
    i_cap_pin_model.pulse(0, 6, 2);
    repeat (4) @(posedge pclk);
    rd(A_CAP0, r);
    rd(A_CAP0 + 8'h4, 32'h0);
    rd(A_STAT, 32'h10);
    chk_irq(1'b1);
    wr(A_STAT, 32'h10);
    chk_irq(1'b0);
    // a rising capture edge clears counter and prescaler.
    wr(A_PRE_LIM, 32'hff);
    wr(A_PRE_CNT, 32'h7);
    wr(A_CCTL, 32'h100);
    i_cap_pin_model.pulse(0, 6, 6);
    rd(A_COUNT, 32'h0);
    rd(A_PRE_CNT, 32'h0);
    // every pin action on both pins.
    wr(A_CCTL, 32'h0);
    wr(A_PRE_LIM, 32'h0);
    wr(A_DMA, 32'h3);
    for (int p = 0; p < 2; p++)
      for (int a = 0; a < 4; a++)
      begin
        lvl = 2'($random(seed));
        nl = lvl;
        nl[p] = (a == 1) ? 1'b0 : (a == 2) ? 1'b1 : (a == 3) ? ~lvl[p] : lvl[p];
        exp_edges += int'(lvl != cur) + int'(nl != lvl);
        cur = nl;
        wr(A_EXTM, 32'(lvl) | (32'(a) << (4 + 2 * p)));
        wr(A_COUNT, 32'h7);
        wr(A_MATCH0 + ADDR_W'(4 * p), 32'h7);
        wr(A_MCTL, 32'h4 << (3 * p));
        wr(A_CTRL, 32'h1);
        repeat (4) @(posedge pclk);
        rd(A_EXTM, (32'(a) << (4 + 2 * p)) | 32'(nl));
        chk({31'h0, match_out}, {31'h0, nl});
      end
    repeat (2) @(posedge pclk);
    chk(33'(i_cap_pin_model.pin_edges), 33'(exp_edges));
    chk(33'(dma0_cnt), 33'ha);
    chk(33'(dma1_cnt), 33'h4);
    report_and_stop;
  end
endmodule : testbench
`default_nettype wire
